// file: verilog/sso_pkg.sv
//==============================================================
// Overview of operation
// RQ1: Pointer store writes the whole selected pointer register to direct or indirect address.
// RQ2: Indirect pointer store writes the value held before any pointer modification.
// RQ3: Index-compat bit clear: loading pointer zero also loads index and compare.
// RQ4: High-step shift moves the sum right 16 when count bit 4 is one.
// RQ5: Low-step shift moves the sum right by count bits 3 to 0.
// RQ6: High then low step give any 0 to 31 right shift in two cycles.
// RQ7: Right shifts fill with zeros, or with sum bit 31 when sign-extend set.
// RQ8: Right shifts never change the carry flag.
// RQ9: Subtract-buffer sets sum to sum minus buffer; buffer stays unchanged.
// RQ10: Carry cleared on borrow from subtract-buffer, set otherwise.
// RQ11: Mapped store takes one cycle, two when source is a peripheral register.
// RQ12: Repeated mapped store takes n cycles, plus n more for peripheral source.
// RQ13: Pointer store takes one cycle, two with operand and code in same block.
// RQ14: Mapped store clears upper nine address bits, always targeting page zero.
// RQ15: Sum, buffer and shifter are 32 bits; subtraction spans all 32 bits.
`default_nettype none
package sso_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] CMD_OFFS = 8'h00;
  localparam logic [7:0] MODE_OFFS = 8'h04;
  localparam logic [7:0] SUM_OFFS = 8'h08;
  localparam logic [7:0] BUF_OFFS = 8'h0C;
  localparam logic [7:0] COUNT_OFFS = 8'h10;
  localparam logic [7:0] STATUS_OFFS = 8'h14;
  localparam logic [7:0] ADDR_OFFS = 8'h18;
  localparam logic [7:0] INDEX_OFFS = 8'h1C;
  localparam logic [7:0] COMPARE_OFFS = 8'h20;
  localparam logic [7:0] PAGE_OFFS = 8'h24;
  localparam logic [7:0] PTR_BASE_OFFS = 8'h40;
  // ==========================================================
  // Field positions
  localparam int MODE_SXM_BIT = 0;
  localparam int MODE_NDX_BIT = 1;
  localparam int MODE_SAME_BLK_BIT = 2;
  localparam int MODE_INDIRECT_BIT = 3;
  localparam int MODE_PERIPH_BIT = 4;
  localparam int MODE_REP_LSB = 8;
  localparam int ADDR_DMA_LSB = 0;
  localparam int ADDR_SEL_LSB = 8;
  localparam int ADDR_MOD_LSB = 12;
  localparam int STAT_CARRY_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  // ==========================================================
  // Sizes, reset values, timing
  localparam int SUM_W = 32;
  localparam int PTR_W = 16;
  localparam int DMA_W = 7;
  localparam int PAGE_W = 9;
  localparam int REP_W = 8;
  localparam int HIGH_SHIFT = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] ONE_CYCLE = 2'h1;
  localparam logic [1:0] TWO_CYCLES = 2'h2;
  localparam logic CARRY_RST = 1'h0;
  localparam logic [SUM_W-1:0] WORD_RST = 32'h0000_0000;
  // ==========================================================
  // Commands and modifications
  typedef enum logic [2:0] {
    OP_NONE, OP_STORE_PTR, OP_HIGH_SHIFT, OP_LOW_SHIFT,
    OP_SUBTRACT, OP_STORE_MAPPED, OP_LOAD_PTR0
  } op_t;
  typedef enum logic [1:0] {
    MOD_NONE, MOD_INC, MOD_DEC, MOD_INDEX
  } ptr_mod_t;
  typedef struct packed {
    logic en;
    logic [PTR_W-1:0] addr;
    logic [PTR_W-1:0] data;
  } mem_wr_t;
endpackage
`default_nettype wire

// file: verilog/shift_store_subtract_ops.sv
`default_nettype none
module shift_store_subtract_ops import sso_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output mem_wr_t mem_wr,
  output logic busy
);
  typedef enum logic {IDLE, RUN} state_t;

  // ==========================================================
  // Architectural state
  logic [SUM_W-1:0] main_sum_register_reg;
  logic [SUM_W-1:0] sum_buffer_register_reg;
  logic [SUM_W-1:0] shift_count_register_reg;
  logic carry_reg;
  logic [PTR_W-1:0] pointer_register_reg [8];
  logic [PTR_W-1:0] index_register_reg;
  logic [PTR_W-1:0] pointer_compare_register_reg;
  logic [PAGE_W-1:0] page_pointer_reg;
  logic [31:0] mode_reg;
  logic [31:0] addr_reg;
  state_t state_reg;
  op_t op_reg;
  logic [1:0] cyc_reg;
  logic [REP_W-1:0] iter_reg;

  // ==========================================================
  // AXI4-Lite slave
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic do_write;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;

  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr >= PTR_BASE_OFFS && s_axi_araddr[7:5] == 3'h2
        && s_axi_araddr[1:0] == 2'h0) begin
      rd_word = {16'h0000, pointer_register_reg[s_axi_araddr[4:2]]};
    end else begin
      unique case (s_axi_araddr)
        CMD_OFFS: rd_word = {29'h0000_0000, op_reg};
        MODE_OFFS: rd_word = mode_reg;
        SUM_OFFS: rd_word = main_sum_register_reg;
        BUF_OFFS: rd_word = sum_buffer_register_reg;
        COUNT_OFFS: rd_word = shift_count_register_reg;
        STATUS_OFFS: rd_word = {30'h0000_0000, busy, carry_reg};
        ADDR_OFFS: rd_word = addr_reg;
        INDEX_OFFS: rd_word = {16'h0000, index_register_reg};
        COMPARE_OFFS: rd_word = {16'h0000, pointer_compare_register_reg};
        PAGE_OFFS: rd_word = {23'h00_0000, page_pointer_reg};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    unique case (awaddr_reg)
      CMD_OFFS, MODE_OFFS, SUM_OFFS, BUF_OFFS, COUNT_OFFS, STATUS_OFFS,
      ADDR_OFFS, INDEX_OFFS, COMPARE_OFFS, PAGE_OFFS: wr_ok = 1'b1;
      default: wr_ok = awaddr_reg[7:5] == 3'h2 && awaddr_reg[1:0] == 2'h0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  logic wr_sel [11];
  logic [31:0] wr_val [11];
  // ==========================================================
  // Write decode; data registers are locked while an op runs
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      wr_sel[i] = 1'b0;
    end
    wr_val[0] = merge(mode_reg, wdata_reg, wstrb_reg);
    wr_val[1] = merge(main_sum_register_reg, wdata_reg, wstrb_reg);
    wr_val[2] = merge(sum_buffer_register_reg, wdata_reg, wstrb_reg);
    wr_val[3] = merge(shift_count_register_reg, wdata_reg, wstrb_reg);
    wr_val[4] = merge(addr_reg, wdata_reg, wstrb_reg);
    wr_val[5] = merge({16'h0000, index_register_reg}, wdata_reg, wstrb_reg);
    wr_val[6] = merge({16'h0000, pointer_compare_register_reg}, wdata_reg,
                      wstrb_reg);
    wr_val[7] = merge({23'h00_0000, page_pointer_reg}, wdata_reg, wstrb_reg);
    wr_val[8] = merge({16'h0000, pointer_register_reg[awaddr_reg[4:2]]},
                      wdata_reg, wstrb_reg);
    wr_val[9] = wdata_reg;
    wr_val[10] = wdata_reg;
    if (do_write && state_reg == IDLE) begin
      unique case (awaddr_reg)
        MODE_OFFS: wr_sel[0] = 1'b1;
        SUM_OFFS: wr_sel[1] = 1'b1;
        BUF_OFFS: wr_sel[2] = 1'b1;
        COUNT_OFFS: wr_sel[3] = 1'b1;
        ADDR_OFFS: wr_sel[4] = 1'b1;
        INDEX_OFFS: wr_sel[5] = 1'b1;
        COMPARE_OFFS: wr_sel[6] = 1'b1;
        PAGE_OFFS: wr_sel[7] = 1'b1;
        CMD_OFFS: wr_sel[9] = wstrb_reg[0];
        STATUS_OFFS: wr_sel[10] = wstrb_reg[0];
        default: wr_sel[8] = wr_ok;
      endcase
    end
  end

  // ==========================================================
  // Execution engine
  op_t cmd_op;
  logic [1:0] iter_len;
  logic [REP_W-1:0] rep_n;
  logic [2:0] sel;
  logic [PTR_W-1:0] cur_ptr;
  logic [PTR_W-1:0] mod_ptr;
  logic [PTR_W-1:0] direct_addr;
  logic [SUM_W-1:0] shifted;
  logic [4:0] shift_amt;
  logic [SUM_W:0] diff;
  logic last_cyc;

  assign cmd_op = op_t'(wdata_reg[2:0]);
  assign rep_n = mode_reg[MODE_REP_LSB +: REP_W];
  assign sel = addr_reg[ADDR_SEL_LSB +: 3];
  assign cur_ptr = pointer_register_reg[sel];
  assign direct_addr = {page_pointer_reg, addr_reg[ADDR_DMA_LSB +: DMA_W]};
  assign last_cyc = state_reg == RUN && cyc_reg == ONE_CYCLE;
  assign diff = {1'b0, main_sum_register_reg}
              - {1'b0, sum_buffer_register_reg}; // RQ9 RQ15

  always_comb begin
    unique case (cmd_op)
      OP_STORE_PTR: iter_len = mode_reg[MODE_SAME_BLK_BIT] ? TWO_CYCLES
                                                          : ONE_CYCLE; // RQ13
      OP_STORE_MAPPED: iter_len = mode_reg[MODE_PERIPH_BIT] ? TWO_CYCLES
                                                            : ONE_CYCLE; // RQ11
      default: iter_len = ONE_CYCLE;
    endcase
  end

  always_comb begin
    unique case (ptr_mod_t'(addr_reg[ADDR_MOD_LSB +: 2]))
      MOD_NONE: mod_ptr = cur_ptr;
      MOD_INC: mod_ptr = cur_ptr + 16'h0001;
      MOD_DEC: mod_ptr = cur_ptr - 16'h0001;
      MOD_INDEX: mod_ptr = cur_ptr + index_register_reg;
    endcase
  end

  // Same shifter serves both steps; only the amount differs
  always_comb begin
    if (op_reg == OP_HIGH_SHIFT) begin
      shift_amt = shift_count_register_reg[4] ? 5'(HIGH_SHIFT) : 5'h00; // RQ4
    end else begin
      shift_amt = {1'b0, shift_count_register_reg[3:0]}; // RQ5 RQ6
    end
    if (mode_reg[MODE_SXM_BIT]) begin
      shifted = SUM_W'($signed(main_sum_register_reg) >>> shift_amt); // RQ7
    end else begin
      shifted = main_sum_register_reg >> shift_amt; // RQ7
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= IDLE;
      op_reg <= OP_NONE;
      cyc_reg <= 2'h0;
      iter_reg <= 8'h00;
      busy <= 1'b0;
    end else if (state_reg == IDLE) begin
      if (wr_sel[9] && cmd_op != OP_NONE) begin
        state_reg <= RUN;
        op_reg <= cmd_op;
        cyc_reg <= iter_len;
        // Repeat of zero still runs once
        iter_reg <= (cmd_op == OP_STORE_MAPPED && rep_n != 8'h00)
                    ? rep_n : 8'h01; // RQ12
        busy <= 1'b1;
      end
    end else if (cyc_reg != ONE_CYCLE) begin
      cyc_reg <= cyc_reg - 2'h1;
    end else if (iter_reg != 8'h01) begin
      iter_reg <= iter_reg - 8'h01;
      cyc_reg <= mode_reg[MODE_PERIPH_BIT] ? TWO_CYCLES : ONE_CYCLE; // RQ12
    end else begin
      state_reg <= IDLE;
      busy <= 1'b0;
    end
  end

  // Data memory write port: one pulse per completed store
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_wr <= '0;
    end else begin
      mem_wr.en <= 1'b0;
      if (last_cyc && op_reg == OP_STORE_PTR) begin
        mem_wr.en <= 1'b1;
        mem_wr.data <= cur_ptr; // RQ1 RQ2
        mem_wr.addr <= mode_reg[MODE_INDIRECT_BIT] ? cur_ptr
                                                   : direct_addr; // RQ1
      end else if (last_cyc && op_reg == OP_STORE_MAPPED) begin
        mem_wr.en <= 1'b1;
        mem_wr.data <= main_sum_register_reg[PTR_W-1:0];
        mem_wr.addr <= {{PAGE_W{1'b0}}, mode_reg[MODE_INDIRECT_BIT]
                        ? cur_ptr[DMA_W-1:0]
                        : addr_reg[ADDR_DMA_LSB +: DMA_W]}; // RQ14
      end
    end
  end

  // Sum and carry
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_sum_register_reg <= WORD_RST;
      carry_reg <= CARRY_RST;
    end else if (last_cyc) begin
      unique case (op_reg)
        OP_HIGH_SHIFT, OP_LOW_SHIFT: begin
          main_sum_register_reg <= shifted; // RQ6 RQ8
        end
        OP_SUBTRACT: begin
          main_sum_register_reg <= diff[SUM_W-1:0]; // RQ9
          carry_reg <= ~diff[SUM_W]; // RQ10
        end
        default: begin
        end
      endcase
    end else begin
      if (wr_sel[1]) begin
        main_sum_register_reg <= wr_val[1];
      end
      if (wr_sel[10]) begin
        carry_reg <= wdata_reg[STAT_CARRY_BIT];
      end
    end
  end

  // Buffer, count, mode and address are software-owned
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sum_buffer_register_reg <= WORD_RST;
      shift_count_register_reg <= WORD_RST;
      mode_reg <= WORD_RST;
      addr_reg <= WORD_RST;
      page_pointer_reg <= '0;
    end else begin
      if (wr_sel[0]) mode_reg <= wr_val[0];
      if (wr_sel[2]) sum_buffer_register_reg <= wr_val[2];
      if (wr_sel[3]) shift_count_register_reg <= wr_val[3];
      if (wr_sel[4]) addr_reg <= wr_val[4];
      if (wr_sel[7]) page_pointer_reg <= wr_val[7][PAGE_W-1:0];
    end
  end

  // Pointer file, index and compare
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        pointer_register_reg[i] <= '0;
      end
      index_register_reg <= '0;
      pointer_compare_register_reg <= '0;
    end else if (last_cyc && op_reg == OP_STORE_PTR) begin
      // Update on the same edge as the store, so the old value is written out
      if (mode_reg[MODE_INDIRECT_BIT]) begin
        pointer_register_reg[sel] <= mod_ptr; // RQ2
      end
    end else if (last_cyc && op_reg == OP_LOAD_PTR0) begin
      pointer_register_reg[0] <= main_sum_register_reg[PTR_W-1:0];
      if (!mode_reg[MODE_NDX_BIT]) begin
        index_register_reg <= main_sum_register_reg[PTR_W-1:0]; // RQ3
        pointer_compare_register_reg <=
          main_sum_register_reg[PTR_W-1:0]; // RQ3
      end
    end else begin
      if (wr_sel[5]) index_register_reg <= wr_val[5][PTR_W-1:0];
      if (wr_sel[6]) pointer_compare_register_reg <= wr_val[6][PTR_W-1:0];
      if (wr_sel[8]) begin
        pointer_register_reg[awaddr_reg[4:2]] <= wr_val[8][PTR_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/sso_chk_sva.sv
`default_nettype none
module sso_chk import sso_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire mem_wr_t mem_wr,
  input wire logic busy
);
  // ==========
  // Last command taken while idle
  op_t op_reg;
  logic cmd_take;
  // Bench offers address and data together, so one edge suffices
  assign cmd_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && s_axi_awaddr == CMD_OFFS && s_axi_wstrb[0] && !busy;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_reg <= OP_NONE;
    end else if (cmd_take) begin
      op_reg <= op_t'(s_axi_wdata[2:0]);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // Checks
  chk_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid) else $error("write unanswered");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read unanswered");
  chk_slots_closed:
    assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      and (s_axi_rvalid |-> !s_axi_arready)) else $error("slot open");
  chk_unmapped_read:
    assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr
      inside {[8'h28:8'h3C], [8'h60:8'hFF]}) |=> s_axi_rresp ==
      RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  chk_busy_start:
    assert property ($rose(busy) |-> $rose(s_axi_bvalid))
      else $error("busy rose without command");
  chk_busy_bound:
    assert property (busy |-> ##[1:520] !busy) else $error("busy stuck");
  chk_short_ops:
    assert property ($rose(busy) && (op_reg inside {OP_HIGH_SHIFT,
      OP_LOW_SHIFT, OP_SUBTRACT}) |-> ##[1:2] !busy)
      else $error("one-cycle op too long");
  chk_ptr_store:
    assert property ($rose(busy) && op_reg == OP_STORE_PTR |->
      ##[1:3] !busy) else $error("pointer store too long");
  chk_ptr_written:
    assert property ($rose(busy) && op_reg == OP_STORE_PTR |->
      ##[1:4] mem_wr.en) else $error("pointer store not written");
  chk_page_zero:
    assert property (mem_wr.en && op_reg == OP_STORE_MAPPED |->
      mem_wr.addr[15:7] == 9'h0) else $error("mapped store off page");
endmodule
bind shift_store_subtract_ops sso_chk chk_i (.clk, .sys_rst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_wr,
  .busy);
`default_nettype wire

// file: bench/shift_store_subtract_ops_tb.sv
`default_nettype none
module shift_store_subtract_ops_tb import sso_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, busy, s, c;
  logic [7:0] s_axi_awaddr, s_axi_araddr, pa, n;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd, v, b, e;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] st_addr, st_data, p, x, ex;
  logic [4:0] k;
  logic [4:0] kc [4] = '{5'h00, 5'h0F, 5'h10, 5'h1F};
  mem_wr_t mem_wr;
  int bad_count, cmp_count, cyc, busy_cnt, pulse_cnt, base, nn;

  shift_store_subtract_ops dut (.clk, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_wr,
    .busy);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] nxt(logic [31:0] q);
    return {q[30:0], q[31] ^ q[21] ^ q[1] ^ q[0]};
  endfunction

  function automatic logic [31:0] shr(logic [31:0] q, logic [4:0] m,
      logic se);
    return se ? 32'($signed(q) >>> m) : q >> m;
  endfunction

  task automatic test_done();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ==========
  // Bus master, entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) aw = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w = 1'b1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!(aw && w));
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic op(input op_t o);
    busy_cnt = 0;
    pulse_cnt = 0;
    wr(CMD_OFFS, {29'h0, o});
    while (busy !== 1'b0) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  // ==========
  // Busy length, store pulses, hang guard
  always @(posedge clk) begin
    cyc++;
    if (busy === 1'b1) busy_cnt++;
    if (mem_wr.en === 1'b1) begin
      pulse_cnt++;
      st_addr = mem_wr.addr;
      st_data = mem_wr.data;
    end
    if (cyc == 40000) begin
      bad_count++;
      $display("[ERR] %0t run too long", $time);
      test_done();
    end
  end

  initial begin
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    seed = 32'h0C3F;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdr(SUM_OFFS);
    chk(rd, WORD_RST);
    rdr(STATUS_OFFS);
    chk(rd, {31'h0, CARRY_RST});
    rdr(8'h30);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(8'h30, 32'h1);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    // ==========
    // Subtract; corners: equal, a plain case, full borrow
    for (int i = 0; i < 12; i++) begin
      seed = nxt(seed);
      v = seed;
      b = nxt(seed);
      if (i == 0) b = v;
      if (i == 1) {v, b} = {32'h2000_0000, 32'h1000_0000};
      if (i == 2) {v, b} = {32'h0, 32'hFFFF_FFFF};
      wr(SUM_OFFS, v);
      wr(BUF_OFFS, b);
      wr(STATUS_OFFS, {31'h0, ~v[3]});
      op(OP_SUBTRACT);
      chk(32'(busy_cnt), 32'h1);
      rdr(SUM_OFFS);
      chk(rd, v - b);
      rdr(BUF_OFFS);
      chk(rd, b);
      rdr(STATUS_OFFS);
      chk({31'h0, rd[0]}, {31'h0, v >= b});
    end
    // ==========
    // Two-step right shift; count bits above 4 are noise
    for (int i = 0; i < 24; i++) begin
      seed = nxt(seed);
      v = (i < 4) ? 32'hFFFF_0000 : nxt(seed);
      k = (i < 4) ? kc[i] : seed[4:0];
      s = (i < 4) ? i[0] : seed[5];
      c = seed[6];
      wr(SUM_OFFS, v);
      wr(COUNT_OFFS, {seed[31:5], k});
      wr(MODE_OFFS, {31'h0, s});
      wr(STATUS_OFFS, {31'h0, c});
      op(OP_HIGH_SHIFT);
      rdr(SUM_OFFS);
      chk(rd, shr(v, k & 5'h10, s));
      op(OP_LOW_SHIFT);
      rdr(SUM_OFFS);
      chk(rd, shr(v, k, s));
      rdr(STATUS_OFFS);
      chk({31'h0, rd[0]}, {31'h0, c});
    end
    // ==========
    // Pointer store over every modify kind, direct and indirect
    for (int i = 0; i < 16; i++) begin
      seed = nxt(seed);
      e = nxt(seed);
      p = seed[31:16];
      x = e[31:16];
      pa = PTR_BASE_OFFS + {3'h0, seed[2:0], 2'h0};
      wr(pa, {16'h0, p});
      wr(PAGE_OFFS, {23'h0, e[8:0]});
      wr(INDEX_OFFS, {16'h0, x});
      wr(ADDR_OFFS, {18'h0, i[1:0], 1'b0, seed[2:0], 1'b0, e[15:9]});
      wr(MODE_OFFS, {28'h0, i[2], i[3], 2'b10});
      op(OP_STORE_PTR);
      chk(32'(pulse_cnt), 32'h1);
      chk({16'h0, st_data}, {16'h0, p});
      chk({16'h0, st_addr}, {16'h0, i[2] ? p : {e[8:0], e[15:9]}});
      chk(32'(busy_cnt - base), i[3] ? 32'h2 : 32'h1);
      ex = p;
      if (i[2] && i[1:0] == 2'h1) ex = p + 16'h1;
      if (i[2] && i[1:0] == 2'h2) ex = p - 16'h1;
      if (i[2] && i[1:0] == 2'h3) ex = p + x;
      rdr(pa);
      chk(rd, {16'h0, ex});
    end
    // ==========
    // Mapped store, page and pointer high bits all ones
    for (int i = 0; i < 6; i++) begin
      seed = nxt(seed);
      n = (i < 2) ? 8'(i) : {5'h0, seed[2:0]} + 8'h2;
      nn = (n == 8'h0) ? 1 : int'(n);
      wr(SUM_OFFS, seed);
      wr(PAGE_OFFS, 32'h1FF);
      wr(PTR_BASE_OFFS, {16'h0, 9'h1FF, seed[22:16]});
      wr(ADDR_OFFS, {25'h0, seed[14:8]});
      wr(MODE_OFFS, {16'h0, n, 3'h0, i[0], i[1], 3'h2});
      op(OP_STORE_MAPPED);
      chk(32'(pulse_cnt), 32'(nn));
      chk(32'(busy_cnt - base), 32'(nn * (i[0] ? 2 : 1)));
      chk({16'h0, st_addr}, {25'h0, i[1] ? seed[22:16] : seed[14:8]});
      chk({16'h0, st_data}, {16'h0, seed[15:0]});
    end
    // ==========
    // Pointer zero load with index-compat clear, then set
    for (int i = 0; i < 2; i++) begin
      seed = nxt(seed);
      wr(INDEX_OFFS, 32'h0);
      wr(COMPARE_OFFS, 32'h0);
      wr(MODE_OFFS, {30'h0, i[0], 1'b0});
      wr(SUM_OFFS, seed);
      op(OP_LOAD_PTR0);
      rdr(PTR_BASE_OFFS);
      chk(rd, {16'h0, seed[15:0]});
      rdr(INDEX_OFFS);
      chk(rd, i[0] ? 32'h0 : {16'h0, seed[15:0]});
      rdr(COMPARE_OFFS);
      chk(rd, i[0] ? 32'h0 : {16'h0, seed[15:0]});
    end
    test_done();
  end
endmodule
`default_nettype wire
